// ==== tb/itm_far_model.sv ====
// time source and frame generator standing beside the block
`timescale 1ns/1ps

module itm_far_model
    import itm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // time source
    output itm_pkg::itm_time_t irigTime,
    output logic usTick,
    // frame generator
    input wire logic frameStart,
    output logic frameDone
);
    logic [1:0] div;
    int busy;

    // one tick every four clocks; the time moves on at each tick
    always_ff @(posedge mclk) begin
        if (rst) begin
            div <= 2'd0;
            usTick <= 1'b0;
            irigTime <= '0;
        end else begin
            div <= div + 2'd1;
            usTick <= (div == 2'd2);
            if (usTick) begin
                irigTime.dig[0] <= (irigTime.dig[0] == 4'h9) ? 4'h0 :
                    irigTime.dig[0] + 4'h1;
                if (irigTime.dig[0] == 4'h9) begin
                    irigTime.dig[1] <= (irigTime.dig[1] == 4'h9) ? 4'h0 :
                        irigTime.dig[1] + 4'h1;
                end
            end
        end
    end

    // each frame takes twenty clocks before it reports done
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy <= 0;
            frameDone <= 1'b0;
        end else begin
            frameDone <= (busy == 1);
            if (frameStart) begin
                busy <= 20;
            end else if (busy > 0) begin
                busy <= busy - 1;
            end
        end
    end
endmodule : itm_far_model

// ==== tb/tb_irig_time_match_frame_trigger.sv ====
// self-checking bench for the time match and frame trigger block
`timescale 1ns/1ps
`include "itm_params.svh"

module tb_irig_time_match_frame_trigger;
    import itm_pkg::*;
    logic mclk, rst, wbCyc, wbStb, wbWe, wbAck, videoSync, frameDone;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR, q;
    itm_time_t irigTime;
    logic usTick, syncOut, frameStart, fpaEnable, pixVal, pixOutVal;
    logic frameEnd;
    logic [1:0] framePreset;
    logic [23:0] effPeriod, effInteg;
    itm_win_t winOut, nucWin;
    itm_pix_t pixIn, pixOut;
    int nFail = 0, compares = 0, cycles = 0;
    logic [1:0] presets[$];

    itm_top u_dut (.mclk(mclk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
        .wbDatR(wbDatR), .wbAck(wbAck), .irigTime(irigTime),
        .usTick(usTick), .videoSync(videoSync), .frameDone(frameDone),
        .syncOut(syncOut), .frameStart(frameStart),
        .framePreset(framePreset), .effPeriod(effPeriod),
        .effInteg(effInteg), .fpaEnable(fpaEnable), .winOut(winOut),
        .nucWin(nucWin), .pixVal(pixVal), .pixIn(pixIn),
        .frameEnd(frameEnd),
        .pixOutVal(pixOutVal), .pixOut(pixOut));
    itm_far_model u_far (.mclk(mclk), .rst(rst), .irigTime(irigTime),
        .usTick(usTick), .frameStart(frameStart), .frameDone(frameDone));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (frameStart === 1'b1) presets.push_back(framePreset);
        if (cycles > 20000) begin
            nFail++;
            results();
        end
    end

    task chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            nFail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        do begin
            @(posedge mclk);
        end while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge mclk);
    endtask : wb

    task regReset();
        wb(0, `ITM_A_CTRL, 0);
        chk(q, `ITM_RST_CTRL);
        chk(fpaEnable, 1'b1);
        wb(0, `ITM_A_WILD, 0);
        chk(q, 32'h0003_FFFF);
        wb(0, 8'h3C, 0);
        chk(q, 0);
    endtask : regReset

    task timeMatch();
        logic e;
        wb(1, `ITM_A_PAT0, 32'h0000_0005);
        wb(1, `ITM_A_WILD, 32'h0003_FFFE);
        while (usTick !== 1'b1) @(posedge mclk);
        e = (irigTime.dig[0] == 4'h5);
        repeat (120) begin
            @(posedge mclk);
            if (usTick === 1'b1) e = (irigTime.dig[0] == 4'h5);
            #1 chk(syncOut, e);
        end
    endtask : timeMatch

    task seq(input logic [31:0] ctrl, input int n, input logic [1:0] p0);
        logic [1:0] order[6];
        order = '{2'd0, 2'd1, 2'd1, 2'd3, 2'd3, 2'd3};
        wb(1, `ITM_A_CTRL, ctrl);
        presets.delete();
        videoSync <= 1'b1;
        @(posedge mclk);
        videoSync <= 1'b0;
        // second sync rises while busy and stays high past the first frame
        repeat (5) @(posedge mclk);
        videoSync <= 1'b1;
        repeat (30) @(posedge mclk);
        videoSync <= 1'b0;
        repeat (400) @(posedge mclk);
        chk(presets.size(), (n == 0) ? 1 : 6 * n);
        foreach (presets[k]) chk(presets[k], (n == 0) ? p0 : order[k % 6]);
    endtask : seq

    task bounds();
        wb(1, `ITM_A_PERIOD, 32'h0000_1000);
        wb(1, `ITM_A_INTEG, 32'h0000_0F80);
        repeat (2) @(posedge mclk);
        chk(effPeriod, 24'h00_1080);
        wb(1, `ITM_A_CTRL, 32'h0000_0050);
        wb(1, `ITM_A_INTEG, 32'h0000_2000);
        repeat (2) @(posedge mclk);
        chk(effInteg, 24'h00_0F80);
        wb(1, `ITM_A_CTRL, 32'h0000_0060);
        repeat (2) @(posedge mclk);
        chk(effPeriod, 24'h00_2100);
    endtask : bounds

    task stats();
        pixIn <= '{16'h0000, 16'h0000, 16'h0002};
        pixVal <= 1'b1;
        @(posedge mclk);
        pixIn.data <= 16'h0004;
        @(posedge mclk);
        pixVal <= 1'b0;
        frameEnd <= 1'b1;
        @(posedge mclk);
        frameEnd <= 1'b0;
        repeat (150) @(posedge mclk);
        wb(0, `ITM_A_MINMAX, 0);
        chk(q, 32'h0004_0002);
        wb(0, `ITM_A_MEANSD, 0);
        chk(q, 32'h0001_0003);
    endtask : stats

    task window();
        wb(1, `ITM_A_WINWH, 32'h0010_0020);
        chk(winOut.w, 16'h0280);
        wb(1, `ITM_A_APPLY, 0);
        chk({winOut.h, winOut.w}, 32'h0010_0020);
        chk(nucWin, 64'h0000_0000_0010_0020);
        wb(1, `ITM_A_CTRL, 32'h0000_03C0);
        chk({nucWin.h, nucWin.w}, 32'h0200_0280);
        pixIn <= '{16'h0002, 16'h0003, 16'h0123};
        pixVal <= 1'b1;
        @(posedge mclk);
        pixVal <= 1'b0;
        #1 chk(pixOut, {16'h000D, 16'h001C, 16'h0123});
        chk(pixOutVal, 1'b1);
        wb(1, `ITM_A_CTRL, 32'h0000_0000);
        pixVal <= 1'b1;
        @(posedge mclk);
        pixVal <= 1'b0;
        #1 chk(pixOut.data, `ITM_BLANK);
    endtask : window

    task results();
        $display("comparisons %0d mismatches %0d", compares, nFail);
        if (nFail == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    initial begin
        rst = 1'b1;
        {wbCyc, wbStb, wbWe, videoSync, pixVal, frameEnd} = '0;
        wbAdr = '0;
        wbSel = 4'hF;
        wbDatW = '0;
        pixIn = '0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        regReset();
        timeMatch();
        wb(1, `ITM_A_DWELL, 32'h0300_0201);
        wb(1, `ITM_A_SEQCNT, 32'h0000_0002);
        seq(32'h0000_084C, 0, 2'd2);
        seq(32'h0000_004D, 1, 2'd0);
        seq(32'h0000_004E, 2, 2'd0);
        bounds();
        stats();
        window();
        results();
    end
endmodule : tb_irig_time_match_frame_trigger

// ==== verilog/itm_params.svh ====
// register map, field positions, reset values and timing counts
`ifndef ITM_PARAMS_SVH
`define ITM_PARAMS_SVH

`define ITM_A_CTRL 8'h00
`define ITM_A_PAT0 8'h04
`define ITM_A_PAT1 8'h08
`define ITM_A_PAT2 8'h0C
`define ITM_A_WILD 8'h10
`define ITM_A_DWELL 8'h14
`define ITM_A_SEQCNT 8'h18
`define ITM_A_PERIOD 8'h1C
`define ITM_A_INTEG 8'h20
`define ITM_A_WINWH 8'h24
`define ITM_A_WINXY 8'h28
`define ITM_A_APPLY 8'h2C
`define ITM_A_MINMAX 8'h30
`define ITM_A_MEANSD 8'h34
`define ITM_A_STATUS 8'h38

`define ITM_B_MODE 1:0
`define ITM_B_SRC 2
`define ITM_B_RISE 3
`define ITM_B_PRIO 5:4
`define ITM_B_FPAEN 6
`define ITM_B_VFLIP 7
`define ITM_B_HFLIP 8
`define ITM_B_NUCFULL 9
`define ITM_B_ACTPRE 11:10
`define ITM_CTRL_MASK 32'h0000_0FFF

`define ITM_RST_CTRL 32'h0000_0040
`define ITM_RST_PERIOD 24'h05_1615
`define ITM_RST_INTEG 24'h00_CB20
`define ITM_RST_WINWH 32'h0200_0280

// cycles between end of integration and next frame start
`define ITM_OVH 24'h00_0100
// level delivered while the detector is off
`define ITM_BLANK 16'h2000

`endif

// ==== verilog/itm_pkg.sv ====
// types shared by the time match and frame trigger block
package itm_pkg;
    typedef struct packed {
        logic [17:0][3:0] dig;
    } itm_time_t;
    typedef struct packed {
        logic [15:0] y;
        logic [15:0] x;
        logic [15:0] h;
        logic [15:0] w;
    } itm_win_t;
    typedef struct packed {
        logic [15:0] row;
        logic [15:0] col;
        logic [15:0] data;
    } itm_pix_t;
    typedef enum logic [1:0] {
        ITM_ACTIVE, ITM_SEQ, ITM_TRIGSEQ, ITM_MODE_RSV
    } itm_mode_t;
    typedef enum logic [1:0] {
        ITM_PRI_NONE, ITM_PRI_FRAME, ITM_PRI_INTEG, ITM_PRI_RSV
    } itm_prio_t;
endpackage : itm_pkg

// ==== verilog/itm_top.sv ====
// IRIG time match, frame sequencer and imaging controls
`timescale 1ns/1ps
`include "itm_params.svh"

module itm_top #(
    parameter int PIX_W = 14,
    parameter int ARRAY_W = 640,
    parameter int ARRAY_H = 512,
    parameter int CNT_W = 20
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    // time source
    input wire itm_pkg::itm_time_t irigTime,
    input wire logic usTick,
    // sync and frame generator
    input wire logic videoSync,
    input wire logic frameDone,
    output logic syncOut,
    output logic frameStart,
    output logic [1:0] framePreset,
    output logic [23:0] effPeriod,
    output logic [23:0] effInteg,
    output logic fpaEnable,
    // window
    output itm_pkg::itm_win_t winOut,
    output itm_pkg::itm_win_t nucWin,
    // pixel path
    input wire logic pixVal,
    input wire itm_pkg::itm_pix_t pixIn,
    input wire logic frameEnd,
    output logic pixOutVal,
    output itm_pkg::itm_pix_t pixOut
);
    import itm_pkg::*;

    localparam int SUM_W = PIX_W + CNT_W;
    localparam int SQ_W = 2 * PIX_W + CNT_W;

    if (PIX_W < 2 || PIX_W > 16 || CNT_W < 1 || CNT_W > 24)
        $error("itm_top: unsupported pixel or count width");

    function automatic logic [31:0] merge(input logic [31:0] o,
            input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i+:8] = n[8*i+:8];
            end
        end
        return r;
    endfunction : merge

    // bus decode
    wire wbReq = wbCyc & wbStb & ~wbAck;
    wire wr = wbReq & wbWe;
    wire wCtrl = wr && wbAdr == `ITM_A_CTRL;
    wire wPat0 = wr && wbAdr == `ITM_A_PAT0;
    wire wPat1 = wr && wbAdr == `ITM_A_PAT1;
    wire wPat2 = wr && wbAdr == `ITM_A_PAT2;
    wire wWild = wr && wbAdr == `ITM_A_WILD;
    wire wDwell = wr && wbAdr == `ITM_A_DWELL;
    wire wSeq = wr && wbAdr == `ITM_A_SEQCNT;
    wire wPer = wr && wbAdr == `ITM_A_PERIOD;
    wire wInt = wr && wbAdr == `ITM_A_INTEG;
    wire wWh = wr && wbAdr == `ITM_A_WINWH;
    wire wXy = wr && wbAdr == `ITM_A_WINXY;
    wire applyHit = wr && wbAdr == `ITM_A_APPLY;

    logic [31:0] ctrl;
    logic [71:0] pat;
    logic [17:0] wild;
    logic [31:0] dwell;
    logic [7:0] seqCnt;
    logic [23:0] period;
    logic [23:0] integ;
    logic [31:0] winWh;
    logic [31:0] winXy;
    wire [31:0] wildM = merge({14'h0000, wild}, wbDatW, wbSel);

    wire itm_mode_t mode = itm_mode_t'(ctrl[`ITM_B_MODE]);
    wire itm_prio_t prio = itm_prio_t'(ctrl[`ITM_B_PRIO]);
    wire srcVideo = ctrl[`ITM_B_SRC];
    wire rise = ctrl[`ITM_B_RISE];
    wire fpaEn = ctrl[`ITM_B_FPAEN];
    wire vflip = ctrl[`ITM_B_VFLIP];
    wire hflip = ctrl[`ITM_B_HFLIP];
    wire nucFull = ctrl[`ITM_B_NUCFULL];
    wire [1:0] actPre = ctrl[`ITM_B_ACTPRE];

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl <= `ITM_RST_CTRL;
            pat <= 72'h00_0000_0000_0000_0000;
            wild <= 18'h3_FFFF;
            dwell <= 32'h0101_0101;
            seqCnt <= 8'h01;
        end else begin
            if (wCtrl)
                ctrl <= merge(ctrl, wbDatW, wbSel) & `ITM_CTRL_MASK;
            if (wPat0)
                pat[31:0] <= merge(pat[31:0], wbDatW, wbSel);
            if (wPat1)
                pat[63:32] <= merge(pat[63:32], wbDatW, wbSel);
            if (wPat2 && wbSel[0])
                pat[71:64] <= wbDatW[7:0];
            if (wWild)
                wild <= wildM[17:0];
            if (wDwell)
                dwell <= merge(dwell, wbDatW, wbSel);
            if (wSeq && wbSel[0])
                seqCnt <= wbDatW[7:0];
        end
    end

    // frame period and integration time bounding
    wire [31:0] perM = merge({8'h00, period}, wbDatW, wbSel);
    wire [31:0] intM = merge({8'h00, integ}, wbDatW, wbSel);
    wire [23:0] perW = perM[23:0];
    wire [23:0] intW = intM[23:0];
    wire [24:0] intPlus = {1'b0, integ} + {1'b0, `ITM_OVH};
    wire [24:0] intWPlus = {1'b0, intW} + {1'b0, `ITM_OVH};
    wire [23:0] perRoom = period > `ITM_OVH ? period - `ITM_OVH : 24'h00_0000;
    wire noPri = prio == ITM_PRI_NONE;
    logic [23:0] next_period;
    logic [23:0] next_integ;

    always_comb begin
        next_period = period;
        next_integ = integ;
        if (wPer) begin
            next_period = perW;
            if (noPri && perW > `ITM_OVH && intPlus > {1'b0, perW})
                next_integ = perW - `ITM_OVH;
        end
        if (wInt) begin
            next_integ = intW;
            if (noPri && intWPlus > {1'b0, period})
                next_period = intWPlus[23:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            period <= `ITM_RST_PERIOD;
            integ <= `ITM_RST_INTEG;
            effPeriod <= `ITM_RST_PERIOD;
            effInteg <= `ITM_RST_INTEG;
        end else begin
            period <= next_period;
            integ <= next_integ;
            effPeriod <= (prio == ITM_PRI_INTEG && intPlus > {1'b0, period})
                ? intPlus[23:0] : period;
            effInteg <= (prio == ITM_PRI_FRAME && intPlus > {1'b0, period})
                ? perRoom : integ;
        end
    end

    // time comparator, one hit per digit
    logic [17:0] digHit;
    for (genvar g = 0; g < 18; g++) begin : gDig
        assign digHit[g] = wild[g] | (pat[4*g+:4] == irigTime.dig[g]);
    end
    wire allHit = &digHit;

    always_ff @(posedge mclk) begin
        if (rst)
            syncOut <= 1'b0;
        else if (usTick)
            syncOut <= allHit;
    end

    // sync selection and trigger
    logic syncPrev;
    wire syncSel = srcVideo ? videoSync : syncOut;
    always_ff @(posedge mclk) begin
        if (rst)
            syncPrev <= 1'b0;
        else
            syncPrev <= syncSel;
    end
    wire syncEv = rise ? syncSel & ~syncPrev : syncSel;

    // frame sequencer
    typedef enum logic [1:0] {SQ_IDLE, SQ_LOAD, SQ_FRAME, SQ_WAIT} sq_t;
    sq_t sq;
    logic [1:0] preIdx;
    logic [7:0] frmCnt;
    logic [7:0] seqLeft;
    logic single;
    wire trig = sq == SQ_IDLE && syncEv;
    wire [7:0] dwellCur = dwell[8*preIdx+:8];
    wire moreFrm = frmCnt < dwellCur;
    wire lastPre = preIdx == 2'd3;

    always_ff @(posedge mclk) begin
        if (rst) begin
            sq <= SQ_IDLE;
            preIdx <= 2'd0;
            frmCnt <= 8'h00;
            seqLeft <= 8'h00;
            single <= 1'b0;
            frameStart <= 1'b0;
            framePreset <= 2'd0;
        end else begin
            frameStart <= 1'b0;
            case (sq)
                SQ_IDLE: begin
                    if (trig && mode == ITM_ACTIVE) begin
                        single <= 1'b1;
                        preIdx <= actPre;
                        sq <= SQ_FRAME;
                    end else if (trig) begin
                        single <= 1'b0;
                        preIdx <= 2'd0;
                        frmCnt <= 8'h00;
                        seqLeft <= mode == ITM_TRIGSEQ ? seqCnt : 8'h01;
                        sq <= SQ_LOAD;
                    end
                end
                SQ_LOAD: begin
                    if (moreFrm) begin
                        sq <= SQ_FRAME;
                    end else begin
                        frmCnt <= 8'h00;
                        preIdx <= preIdx + 2'd1;
                        if (lastPre) begin
                            seqLeft <= seqLeft - 8'h01;
                            if (seqLeft <= 8'h01)
                                sq <= SQ_IDLE;
                        end
                    end
                end
                SQ_FRAME: begin
                    frameStart <= 1'b1;
                    framePreset <= preIdx;
                    sq <= SQ_WAIT;
                end
                SQ_WAIT: begin
                    if (frameDone) begin
                        frmCnt <= frmCnt + 8'h01;
                        sq <= single ? SQ_IDLE : SQ_LOAD;
                    end
                end
                default: sq <= SQ_IDLE;
            endcase
        end
    end

    // window shadow and apply
    always_ff @(posedge mclk) begin
        if (rst) begin
            winWh <= `ITM_RST_WINWH;
            winXy <= 32'h0000_0000;
            winOut <= {32'h0000_0000, `ITM_RST_WINWH};
            nucWin <= {32'h0000_0000, `ITM_RST_WINWH};
        end else begin
            if (wWh)
                winWh <= merge(winWh, wbDatW, wbSel);
            if (wXy)
                winXy <= merge(winXy, wbDatW, wbSel);
            if (applyHit)
                winOut <= {winXy, winWh};
            nucWin <= nucFull ? itm_win_t'({32'h0000_0000,
                16'(ARRAY_H), 16'(ARRAY_W)}) : winOut;
        end
    end

    // pixel path
    wire [15:0] pixData = fpaEn ? pixIn.data : `ITM_BLANK;
    always_ff @(posedge mclk) begin
        if (rst) begin
            pixOutVal <= 1'b0;
            pixOut <= '0;
            fpaEnable <= 1'b0;
        end else begin
            fpaEnable <= fpaEn;
            pixOutVal <= pixVal;
            pixOut.data <= pixData;
            pixOut.row <= vflip ? winOut.h - 16'h0001 - pixIn.row
                : pixIn.row;
            pixOut.col <= hflip ? winOut.w - 16'h0001 - pixIn.col
                : pixIn.col;
        end
    end

    // frame statistics
    typedef enum logic [1:0] {ST_IDLE, ST_DIV1, ST_DIV2, ST_SQRT} st_t;
    st_t st;
    wire [PIX_W-1:0] pd = pixData[PIX_W-1:0];
    logic [PIX_W-1:0] accMin, accMax, statMin, statMax, mean, sdev;
    logic [SUM_W-1:0] accSum;
    logic [SQ_W-1:0] accSq, sqHold, divN, divQ;
    logic [CNT_W-1:0] accCnt, cnt, divR;
    logic [5:0] stepI;
    logic [2*PIX_W-1:0] varc;
    wire [CNT_W:0] divT = {divR, divN[SQ_W-1]};
    wire divGe = divT >= {1'b0, cnt};
    wire [2*PIX_W-1:0] meanSq = mean * mean;
    wire [2*PIX_W-1:0] msq = divQ[2*PIX_W-1:0];
    wire [PIX_W-1:0] cand = sdev | (PIX_W'(1) << stepI);
    wire [2*PIX_W-1:0] candSq = cand * cand;
    wire divLast = stepI == 6'(SQ_W - 1);

    always_ff @(posedge mclk) begin
        if (rst || frameEnd) begin
            accMin <= '1;
            accMax <= '0;
            accSum <= '0;
            accSq <= '0;
            accCnt <= '0;
        end else if (pixVal) begin
            accMin <= pd < accMin ? pd : accMin;
            accMax <= pd > accMax ? pd : accMax;
            accSum <= accSum + SUM_W'(pd);
            accSq <= accSq + SQ_W'(pd) * SQ_W'(pd);
            accCnt <= accCnt + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= ST_IDLE;
            statMin <= '0;
            statMax <= '0;
            mean <= '0;
            sdev <= '0;
            sqHold <= '0;
            divN <= '0;
            divQ <= '0;
            divR <= '0;
            cnt <= '0;
            stepI <= '0;
            varc <= '0;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (frameEnd && accCnt != '0) begin
                        statMin <= accMin;
                        statMax <= accMax;
                        cnt <= accCnt;
                        divN <= SQ_W'(accSum);
                        sqHold <= accSq;
                        divR <= '0;
                        stepI <= '0;
                        st <= ST_DIV1;
                    end
                end
                ST_DIV1, ST_DIV2: begin
                    divR <= divGe ? divT[CNT_W-1:0] - cnt : divT[CNT_W-1:0];
                    divQ <= {divQ[SQ_W-2:0], divGe};
                    divN <= {divN[SQ_W-2:0], 1'b0};
                    stepI <= stepI + 6'd1;
                    if (divLast && st == ST_DIV1) begin
                        st <= ST_DIV2;
                        divN <= sqHold;
                        divR <= '0;
                        stepI <= '0;
                    end else if (divLast) begin
                        st <= ST_SQRT;
                        stepI <= 6'(PIX_W - 1);
                        sdev <= '0;
                    end
                    if (st == ST_DIV2 && stepI == 6'd0)
                        mean <= divQ[PIX_W-1:0];
                end
                ST_SQRT: begin
                    if (stepI == 6'(PIX_W - 1))
                        varc <= msq > meanSq ? msq - meanSq : '0;
                    if (stepI != 6'(PIX_W - 1) && candSq <= varc)
                        sdev <= cand;
                    if (stepI == 6'(PIX_W - 1) && candSq <=
                            (msq > meanSq ? msq - meanSq : '0))
                        sdev <= cand;
                    stepI <= stepI - 6'd1;
                    if (stepI == 6'd0)
                        st <= ST_IDLE;
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // read mux and answer
    logic [31:0] rdMux;
    always_comb begin
        case (wbAdr)
            `ITM_A_CTRL: rdMux = ctrl;
            `ITM_A_PAT0: rdMux = pat[31:0];
            `ITM_A_PAT1: rdMux = pat[63:32];
            `ITM_A_PAT2: rdMux = {24'h00_0000, pat[71:64]};
            `ITM_A_WILD: rdMux = {14'h0000, wild};
            `ITM_A_DWELL: rdMux = dwell;
            `ITM_A_SEQCNT: rdMux = {24'h00_0000, seqCnt};
            `ITM_A_PERIOD: rdMux = {8'h00, period};
            `ITM_A_INTEG: rdMux = {8'h00, integ};
            `ITM_A_WINWH: rdMux = winWh;
            `ITM_A_WINXY: rdMux = winXy;
            `ITM_A_MINMAX: rdMux = {16'(statMax), 16'(statMin)};
            `ITM_A_MEANSD: rdMux = {16'(sdev), 16'(mean)};
            `ITM_A_STATUS: rdMux = {26'h000_0000, st != ST_IDLE,
                framePreset, syncOut, sq != SQ_IDLE, 1'b0};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wbAck <= 1'b0;
            wbDatR <= 32'h0000_0000;
        end else begin
            wbAck <= wbReq;
            wbDatR <= wbReq && !wbWe ? rdMux : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_sync_match: assert property (usTick && allHit |=> syncOut)
        else $error("sync not raised on match");
    a_sync_hold: assert property (!usTick && syncOut |=> syncOut)
        else $error("sync dropped between ticks");
    a_wild_all: assert property (usTick && wild == 18'h3_FFFF
        |=> syncOut)
        else $error("all wildcard did not match");
    a_pat_store: assert property (wPat0 && wbSel == 4'hF
        |=> pat[31:0] == $past(wbDatW))
        else $error("pattern word not stored");
    a_rise_only: assert property (rise && syncSel && syncPrev
        |-> !trig)
        else $error("level retriggered in edge mode");
    a_busy_ignore: assert property (sq == SQ_WAIT && !frameDone
        |=> sq == SQ_WAIT)
        else $error("sequencer left wait early");
    a_one_frame: assert property (trig && mode == ITM_ACTIVE
        |=> sq == SQ_FRAME ##1 frameStart && sq == SQ_WAIT)
        else $error("active preset frame not started");
    a_dwell_limit: assert property (sq == SQ_LOAD && !moreFrm
        |=> sq != SQ_FRAME)
        else $error("frame beyond dwell count");
    a_blank_out: assert property (pixVal && !fpaEn
        |=> pixOut.data == `ITM_BLANK)
        else $error("blank level not delivered");
    a_frame_clamp: assert property (prio == ITM_PRI_FRAME
        ##1 prio == ITM_PRI_FRAME |-> {1'b0, effInteg}
        + {1'b0, `ITM_OVH} <= {1'b0, $past(period)}
        || $past(period) <= `ITM_OVH)
        else $error("integration not clamped");
    a_integ_clamp: assert property (prio == ITM_PRI_INTEG
        |=> {1'b0, effPeriod} >= $past(intPlus))
        else $error("period not clamped");
    a_win_apply: assert property (!applyHit |=> $stable(winOut))
        else $error("window changed without apply");
    a_nuc_full: assert property (nucFull |=> nucWin.w == 16'(ARRAY_W)
        && nucWin.h == 16'(ARRAY_H))
        else $error("full window correction scope wrong");

    c_match: cover property (usTick && allHit ##1 syncOut);
    c_seq_end: cover property (sq == SQ_LOAD ##1 sq == SQ_IDLE);
    c_trigseq: cover property (trig && mode == ITM_TRIGSEQ);
    c_stats: cover property (st == ST_SQRT ##1 st == ST_IDLE);
endmodule : itm_top
